// ### src/hp_consts.svh
// Purpose: Constants for the host register port and its register store
// Assumes: Included by the package and by design files by bare name
// Notes: Definitions only
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH

// ****************************************************************
// Widths and sizes
// ****************************************************************
`define HP_ADDR_W 6
`define HP_DATA_W 8
`define HP_NUM_REGS 64

// ****************************************************************
// Register placement and fields
// ****************************************************************
`define HP_FLAG_ADDR 6'h02
`define HP_MASK_ADDR 6'h03
`define HP_PERR_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define HP_REG_RST 8'h00
`define HP_FLAG_RST 8'h00
`define HP_MASK_RST 8'h00
`define HP_ADDR_RST 6'h00

`endif

// ### src/hp_host_port.sv
// Purpose: Asynchronous 8-bit host register port with parity and
//          open-drain acknowledge and interrupt
// Assumes: Host pins are synchronous to i_clk; the pad ring resolves
//          the open-drain and two-way lines from the enables
// Notes: Acknowledge appears two clocks after select low is seen
`timescale 1ns/1ns
`include "hp_consts.svh"

module hp_host_port
    import hp_pkg::*;
(
    input wire logic i_clk,              // Core clock, 10 MHz
    input wire logic i_rst_b,            // Async reset, active low
    input wire logic i_sel_b,            // Host select, active low
    input wire logic i_read,             // Direction, high reads
    input wire hp_addr_t i_reg_addr,     // Register address
    input wire hp_data_t i_bus_data,     // Data line, pad input
    input wire logic i_bus_parity,       // Parity line, pad input
    input wire hp_data_t i_core_event,   // Event pulses from the core
    output logic [`HP_DATA_W-1:0] o_bus_data,  // Data line, pad output
    output logic o_bus_data_oe,          // Data line drive enable
    output logic o_bus_parity,           // Parity line, pad output
    output logic o_bus_parity_oe,        // Parity line drive enable
    output logic o_ack_out,              // Acknowledge level, always low
    output logic o_ack_oe,               // Acknowledge pull-down enable
    output logic o_irq_out,              // Interrupt level, always low
    output logic o_irq_oe,               // Interrupt pull-down enable
    output logic o_wr_stb,               // Good write accepted, pulse
    output logic [`HP_ADDR_W-1:0] o_wr_addr,   // Address of that write
    output logic [`HP_DATA_W-1:0] o_wr_data,   // Data of that write
    output logic [`HP_ADDR_W-1:0] o_perr_addr  // Last bad-parity address
);

    // ************************************************************
    // Declarations
    // ************************************************************
    hp_rf_if rf ();

    hp_state_t state;
    hp_state_t next_state;
    hp_addr_t addr;
    logic is_read;
    logic par_ok;
    logic do_write;
    logic bad_write;
    logic irq_pend;

    // ************************************************************
    // Decodes
    // ************************************************************
    // Closing edge: select seen high while the acknowledge stands
    function automatic logic cycle_ends(input hp_state_t s,
                                        input logic sel_b);
        cycle_ends = (s == HP_ACK) && sel_b;
    endfunction

    // Only the single TAKE edge may commit or refuse a write, so a
    // long select cannot write the same byte twice
    function automatic logic take_write(input hp_state_t s,
                                        input logic rd);
        take_write = (s == HP_TAKE) && !rd;
    endfunction

    // ************************************************************
    // Register store
    // ************************************************************
    hp_regfile hp_regfile_i (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_core_event(i_core_event),
        .rf(rf)
    );

    // ************************************************************
    // Cycle sequencer
    // ************************************************************
    // Next state; no bus clock, the select level moves it out of IDLE and ACK, TAKE always goes on to ACK
    always_comb
    begin
        next_state = state;
        case (state)
            HP_IDLE:
            begin
                if (!i_sel_b)
                begin
                    next_state = HP_TAKE;
                end
            end
            HP_TAKE:
            begin
                next_state = HP_ACK;
            end
            HP_ACK:
            begin
                if (i_sel_b)
                begin
                    next_state = HP_IDLE;
                end
                else
                begin
                    next_state = HP_ACK;
                end
            end
            default:
            begin
                next_state = HP_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= HP_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Request capture
    // ************************************************************
    // Address and direction are valid once select is low, so they are
    // caught on that first edge and held for the rest of the cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            addr <= `HP_ADDR_RST;
            is_read <= 1'b0;
        end
        else if (state == HP_IDLE && !i_sel_b)
        begin
            addr <= i_reg_addr;
            is_read <= i_read;
        end
    end

    // ************************************************************
    // Write path
    // ************************************************************
    // Data is sampled one edge later; host keeps it until acknowledge
    always_comb
    begin
        par_ok = (hp_odd_par(i_bus_data) == i_bus_parity);
        do_write = take_write(state, is_read) && par_ok;
        bad_write = take_write(state, is_read) && !par_ok;
    end

    // A refused write still gets its acknowledge so the host never hangs
    // Store sees the captured address for both reads and writes
    assign rf.wr_en = do_write;
    assign rf.addr = addr;
    assign rf.wdata = i_bus_data;
    assign rf.par_err = bad_write;

    // Core notice of accepted writes
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_wr_stb <= 1'b0;
            o_wr_addr <= `HP_ADDR_RST;
            o_wr_data <= `HP_REG_RST;
        end
        else
        begin
            o_wr_stb <= do_write;
            if (do_write)
            begin
                o_wr_addr <= addr;
                o_wr_data <= i_bus_data;
            end
        end
    end

    // Address of the most recent refused write, for diagnosis
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_perr_addr <= `HP_ADDR_RST;
        end
        else if (bad_write)
        begin
            o_perr_addr <= addr;
        end
    end

    // ************************************************************
    // Read path and line drivers
    // ************************************************************
    // Read data is frozen at acknowledge so a core event cannot make
    // the lines change under the host while it is still sampling
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_bus_data <= `HP_REG_RST;
            o_bus_parity <= 1'b0;
        end
        else if (state == HP_TAKE && is_read)
        begin
            o_bus_data <= rf.rdata;
            o_bus_parity <= hp_odd_par(rf.rdata);
        end
    end

    // Drive enables follow the read acknowledge and drop with select
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_bus_data_oe <= 1'b0;
            o_bus_parity_oe <= 1'b0;
        end
        else if (state == HP_TAKE)
        begin
            o_bus_data_oe <= is_read;
            o_bus_parity_oe <= is_read;
        end
        else if (cycle_ends(state, i_sel_b))
        begin
            o_bus_data_oe <= 1'b0;
            o_bus_parity_oe <= 1'b0;
        end
    end

    // ************************************************************
    // Acknowledge
    // ************************************************************
    // Open drain: the level is always low, only the enable moves
    // Limitation: a host that lifts select during TAKE still sees one
    // acknowledge clock and must wait for it to clear before reusing
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ack_out <= 1'b0;
            o_ack_oe <= 1'b0;
        end
        else if (state == HP_TAKE)
        begin
            o_ack_out <= 1'b0;
            o_ack_oe <= 1'b1;
        end
        else if (cycle_ends(state, i_sel_b))
        begin
            o_ack_out <= 1'b0;
            o_ack_oe <= 1'b0;
        end
        else
        begin
            o_ack_out <= 1'b0;
            o_ack_oe <= o_ack_oe;
        end
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    // Pending while any flag is set and let through by its mask bit
    always_comb
    begin
        irq_pend = |(rf.flags & rf.mask);
    end

    // Registered so the pad never sees a decode glitch
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_irq_out <= 1'b0;
            o_irq_oe <= 1'b0;
        end
        else
        begin
            o_irq_out <= 1'b0;
            o_irq_oe <= irq_pend;
        end
    end

endmodule

// ### src/hp_pkg.sv
// Purpose: Types and shared functions of the host register port
// Assumes: Constants come from hp_consts.svh
// Notes: Odd parity helper is used by both directions of the port
`include "hp_consts.svh"

package hp_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [`HP_ADDR_W-1:0] hp_addr_t;
    typedef logic [`HP_DATA_W-1:0] hp_data_t;

    typedef enum logic [1:0] {
        HP_IDLE = 2'b00,
        HP_TAKE = 2'b01,
        HP_ACK = 2'b10
    } hp_state_t;

    // ************************************************************
    // Functions
    // ************************************************************
    // Parity bit that makes data plus parity hold an odd count of ones
    function automatic logic hp_odd_par(input hp_data_t data);
        hp_odd_par = ~(^data);
    endfunction

endpackage

// ### src/hp_regfile.sv
// Purpose: Sixty-four byte register store with event flags and mask
// Assumes: Writes arrive already checked for parity
// Notes: Flag bits clear by writing one; a set in the same clock wins
`timescale 1ns/1ns
`include "hp_consts.svh"

module hp_regfile
    import hp_pkg::*;
(
    input wire logic i_clk,              // Core clock
    input wire logic i_rst_b,            // Async reset, active low
    input wire hp_data_t i_core_event,   // Event pulses from the core
    hp_rf_if.store rf                    // Sequencer side
);

    // ************************************************************
    // Storage
    // ************************************************************
    hp_data_t mem [`HP_NUM_REGS];
    hp_data_t flags;
    hp_data_t mask;
    hp_data_t set_vec;

    // Sources that raise flags this clock
    always_comb
    begin
        set_vec = i_core_event;
        set_vec[`HP_PERR_BIT] = i_core_event[`HP_PERR_BIT] | rf.par_err;
    end

    // Plain registers, written only by a good write
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < `HP_NUM_REGS; i++)
            begin
                mem[i] <= `HP_REG_RST;
            end
        end
        else if (rf.wr_en)
        begin
            mem[rf.addr] <= rf.wdata;
        end
    end

    // Event flags: sticky, cleared by writing ones, set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            flags <= `HP_FLAG_RST;
        end
        else if (rf.wr_en && rf.addr == `HP_FLAG_ADDR)
        begin
            flags <= (flags & ~rf.wdata) | set_vec;
        end
        else
        begin
            flags <= flags | set_vec;
        end
    end

    // Mask: a one lets the matching flag reach the interrupt
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            mask <= `HP_MASK_RST;
        end
        else if (rf.wr_en && rf.addr == `HP_MASK_ADDR)
        begin
            mask <= rf.wdata;
        end
    end

    // Read path; flag and mask live outside the array
    always_comb
    begin
        if (rf.addr == `HP_FLAG_ADDR)
        begin
            rf.rdata = flags;
        end
        else if (rf.addr == `HP_MASK_ADDR)
        begin
            rf.rdata = mask;
        end
        else
        begin
            rf.rdata = mem[rf.addr];
        end
    end

    assign rf.flags = flags;
    assign rf.mask = mask;

endmodule

// ### src/hp_rf_if.sv
// Purpose: Carrier between the port sequencer and the register store
// Assumes: Single clock domain, no clocking block
// Notes: Write strobe is one clock wide
`timescale 1ns/1ns

interface hp_rf_if;
    import hp_pkg::*;

    logic wr_en;
    hp_addr_t addr;
    hp_data_t wdata;
    hp_data_t rdata;
    logic par_err;
    hp_data_t flags;
    hp_data_t mask;

    modport ctrl (
        output wr_en,
        output addr,
        output wdata,
        output par_err,
        input rdata,
        input flags,
        input mask
    );

    modport store (
        input wr_en,
        input addr,
        input wdata,
        input par_err,
        output rdata,
        output flags,
        output mask
    );
endinterface

// ### testbench/hp_host_model.sv
// Purpose: Behavioural management host driving the register port
// Assumes: Acknowledge wire is pulled up outside
// Notes: Released data shows the inverse of the last value
`timescale 1ns/1ns

module hp_host_model
    import hp_pkg::*;
(
    input wire logic i_clk,       // Core clock
    input wire logic i_ack_b,     // Acknowledge wire, pulled up
    output logic o_sel_b,         // Select, active low
    output logic o_read,          // Direction, high reads
    output hp_addr_t o_reg_addr,  // Register address
    output hp_data_t o_data,      // Data drive
    output logic o_parity,        // Parity drive
    output logic o_oe             // High while host drives data
);
    // ************************************************************
    // Cycle engine
    // ************************************************************
    hp_data_t val;
    logic par;
    int stuck;

    // A released line must not keep looking valid
    assign o_data = o_oe ? val : ~val;
    assign o_parity = o_oe ? par : ~par;

    // Idle levels at time zero
    initial
    begin
        o_sel_b = 1'b1;
        o_read = 1'b0;
        o_reg_addr = 6'h00;
        o_oe = 1'b0;
        val = 8'h00;
        par = 1'b0;
        stuck = 0;
    end

    // One transfer, paced only by select and acknowledge
    task automatic cycle(input logic rd, input hp_addr_t a,
                         input hp_data_t d, input logic p, input int hold);
        int n;
        @(posedge i_clk);
        o_sel_b <= 1'b0;
        o_read <= rd;
        o_reg_addr <= a;
        val <= d;
        par <= p;
        o_oe <= !rd;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (i_ack_b !== 1'b0 && n < 20);
        if (n == 20)
            stuck++;
        repeat (hold) @(posedge i_clk);
        o_sel_b <= 1'b1;
        o_oe <= 1'b0;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (i_ack_b !== 1'b1 && n < 20);
        if (n == 20)
            stuck++;
    endtask
endmodule

// ### testbench/hp_host_port_bench.sv
// Purpose: Self-checking bench for the host register port
// Assumes: Host model drives the port; pads resolved here
// Notes: Expected writes and reads wait in queues for the monitor
`timescale 1ns/1ns
`include "hp_consts.svh"

module hp_host_port_bench;
    import hp_pkg::*;

    // ************************************************************
    // Pads and instances
    // ************************************************************
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    hp_data_t ev = 8'h00;
    wire logic sel_b, rd, h_oe, h_par, pad_par, ack_b, irq_b;
    wire hp_addr_t addr;
    wire hp_data_t h_data, pad_data;
    logic [7:0] o_bus_data, o_wr_data;
    logic [5:0] o_wr_addr, o_perr_addr;
    logic o_bus_data_oe, o_bus_parity, o_bus_parity_oe, o_wr_stb;
    logic o_ack_out, o_ack_oe, o_irq_out, o_irq_oe;
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 35;
    logic [15:0] wr_q[$];
    logic [15:0] rd_q[$];
    hp_data_t d[8];
    logic rd_prev = 1'b0;

    // Pull-ups on the open-drain wires; device wins the data bus
    assign ack_b = o_ack_oe ? o_ack_out : 1'b1;
    assign irq_b = o_irq_oe ? o_irq_out : 1'b1;
    assign pad_data = o_bus_data_oe ? o_bus_data : h_data;
    assign pad_par = o_bus_parity_oe ? o_bus_parity : h_par;

    hp_host_port hp_host_port_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_sel_b(sel_b), .i_read(rd), .i_reg_addr(addr),
        .i_bus_data(pad_data), .i_bus_parity(pad_par), .i_core_event(ev),
        .o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe),
        .o_bus_parity(o_bus_parity), .o_bus_parity_oe(o_bus_parity_oe),
        .o_ack_out(o_ack_out), .o_ack_oe(o_ack_oe), .o_irq_out(o_irq_out),
        .o_irq_oe(o_irq_oe), .o_wr_stb(o_wr_stb), .o_wr_addr(o_wr_addr),
        .o_wr_data(o_wr_data), .o_perr_addr(o_perr_addr));

    hp_host_model hp_host_model_i (.i_clk(i_clk), .i_ack_b(ack_b),
        .o_sel_b(sel_b), .o_read(rd), .o_reg_addr(addr), .o_data(h_data),
        .o_parity(h_par), .o_oe(h_oe));

    // ************************************************************
    // Checking
    // ************************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Accepted write notice against the oldest noted write
    task automatic check_wr(input logic [15:0] got, input logic [15:0] exp);
        check(got, exp);
    endtask

    // Read data, parity and host release against the oldest noted read
    task automatic check_rd(input logic [15:0] got, input logic [15:0] exp);
        check(got, exp);
    endtask

    task automatic close_out();
        check(16'(hp_host_model_i.stuck + wr_q.size() + rd_q.size()),
              16'h0000);
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input hp_addr_t a, input hp_data_t v, input logic ok);
        if (ok)
            wr_q.push_back({2'b00, a, v});
        hp_host_model_i.cycle(1'b0, a, v, ok ? ~^v : ^v, 0);
    endtask

    task automatic rd_reg(input hp_addr_t a, input hp_data_t e, input int h);
        rd_q.push_back({7'h00, ~^e, e});
        hp_host_model_i.cycle(1'b1, a, 8'h00, 1'b0, h);
    endtask

    // Monitor takes the oldest note when a result shows at a pin
    always @(negedge i_clk)
    begin
        if (o_wr_stb === 1'b1)
            check_wr({2'b00, o_wr_addr, o_wr_data},
                     wr_q.size() ? wr_q.pop_front() : 16'hFFFF);
        // Host must have let go of the data lines while the device drives
        if (o_bus_data_oe === 1'b1 && !rd_prev)
            check_rd({6'h00, h_oe, o_bus_parity, o_bus_data},
                     rd_q.size() ? rd_q.pop_front() : 16'hFFFF);
        rd_prev <= (o_bus_data_oe === 1'b1);
    end

    // ************************************************************
    // Clock, watchdog and scenarios
    // ************************************************************
    initial
    begin
        forever #50 i_clk = ~i_clk;
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        #500000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(negedge i_clk);
        check({12'h000, o_ack_oe, o_bus_data_oe, o_irq_oe, o_wr_stb},
              16'h0000);
        // Both ends of the address range, random data
        for (int i = 0; i < 8; i++)
        begin
            d[i] = 8'($random(seed));
            wr(6'(i * 9), d[i], 1'b1);
        end
        for (int i = 0; i < 8; i++)
            rd_reg(6'(i * 9), d[i], i % 3);
        // Bad parity leaves the register alone and raises the flag
        wr(6'h09, ~d[1], 1'b0);
        check({10'h000, o_perr_addr}, 16'h0009);
        rd_reg(6'h09, d[1], 0);
        rd_reg(`HP_FLAG_ADDR, 8'h01, 0);
        check({15'h0000, irq_b}, 16'h0001);
        wr(`HP_MASK_ADDR, 8'h01, 1'b1);
        check({15'h0000, irq_b}, 16'h0000);
        wr(`HP_FLAG_ADDR, 8'h01, 1'b1);
        check({15'h0000, irq_b}, 16'h0001);
        // A masked core event stays off the interrupt line
        @(posedge i_clk);
        ev <= 8'h08;
        @(posedge i_clk);
        ev <= 8'h00;
        repeat (2) @(negedge i_clk);
        check({15'h0000, irq_b}, 16'h0001);
        wr(`HP_MASK_ADDR, 8'h08, 1'b1);
        check({15'h0000, irq_b}, 16'h0000);
        rd_reg(`HP_FLAG_ADDR, 8'h08, 1);
        close_out();
    end
endmodule

// ### testbench/hp_port_checker.sv
// Purpose: Timing checks on the host register port pins
// Assumes: Host pins are synchronous to i_clk
// Notes: Bound to every instance of the port
`timescale 1ns/1ns
`include "hp_consts.svh"

module hp_port_checker
    import hp_pkg::*;
(
    input wire logic i_clk,              // Core clock
    input wire logic i_rst_b,            // Async reset, active low
    input wire logic i_sel_b,            // Host select, active low
    input wire logic i_read,             // Direction, high reads
    input wire hp_addr_t i_reg_addr,     // Register address
    input wire hp_data_t i_bus_data,     // Data at the pad
    input wire logic i_bus_parity,       // Parity at the pad
    input wire logic [`HP_DATA_W-1:0] o_bus_data, // Read data
    input wire logic o_bus_data_oe,      // Data drive enable
    input wire logic o_bus_parity,       // Read parity
    input wire logic o_bus_parity_oe,    // Parity drive enable
    input wire logic o_ack_oe,           // Acknowledge pull-down
    input wire logic o_wr_stb,           // Accepted write pulse
    input wire logic [`HP_ADDR_W-1:0] o_wr_addr, // Written address
    input wire logic [`HP_DATA_W-1:0] o_wr_data  // Written data
);
    // ************************************************************
    // Handshake and data checks
    // ************************************************************
    default clocking dcb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // Latency is fixed, so one clock early is as wrong as one late
    property p_ack_lat;
        $fell(i_sel_b) && !o_ack_oe |-> ##1 !o_ack_oe ##1 o_ack_oe;
    endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("acknowledge latency wrong");
    property p_ack_hold;
        o_ack_oe && !i_sel_b |=> o_ack_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("acknowledge dropped while selected");
    property p_ack_rel;
        o_ack_oe && i_sel_b |=> !o_ack_oe && !o_bus_data_oe
            && !o_bus_parity_oe;
    endproperty
    a_ack_rel: assert property (p_ack_rel)
        else $error("lines not released after select high");
    property p_rd_par;
        o_bus_parity_oe |-> o_bus_data_oe && (o_bus_parity == ~^o_bus_data);
    endproperty
    a_rd_par: assert property (p_rd_par)
        else $error("read parity not odd");
    property p_rd_hold;
        o_bus_data_oe && $past(o_bus_data_oe) |-> o_ack_oe
            && $stable(o_bus_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved during acknowledge");
    property p_ack_dir;
        $rose(o_ack_oe) |-> o_bus_data_oe == $past(i_read, 2);
    endproperty
    a_ack_dir: assert property (p_ack_dir)
        else $error("drive does not follow direction");
    // Write data is taken one edge before the acknowledge shows
    property p_wr_par;
        $rose(o_ack_oe) && !$past(i_read, 2) |->
            o_wr_stb == $past(^{i_bus_data, i_bus_parity});
    endproperty
    a_wr_par: assert property (p_wr_par)
        else $error("write accepted against parity");
    property p_wr_addr;
        o_wr_stb |-> $rose(o_ack_oe) && o_wr_addr == $past(i_reg_addr, 2)
            && o_wr_data == $past(i_bus_data);
    endproperty
    a_wr_addr: assert property (p_wr_addr)
        else $error("write address or data wrong");
endmodule

bind hp_host_port hp_port_checker hp_port_checker_i (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_sel_b(i_sel_b),
    .i_read(i_read),
    .i_reg_addr(i_reg_addr),
    .i_bus_data(i_bus_data),
    .i_bus_parity(i_bus_parity),
    .o_bus_data(o_bus_data),
    .o_bus_data_oe(o_bus_data_oe),
    .o_bus_parity(o_bus_parity),
    .o_bus_parity_oe(o_bus_parity_oe),
    .o_ack_oe(o_ack_oe),
    .o_wr_stb(o_wr_stb),
    .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data)
);
